// >>> hw/crs_core_regs.sv
`timescale 1ns/10ps
`include "crs_defines.svh"
// Summary of operation
// RULE1 - Sixteen registers of 16 bits; non-dedicated ones hold data or addresses.
// RULE2 - Register 0 program counter, 1 stack pointer, 2 status, 3 constants.
// RULE3 - Any pointer register reaches the whole 64 Kbyte space without banking.
// RULE4 - Code, data and peripherals share one address and one data bus.
// RULE5 - Program counter points at next instruction, steps by 2, 4 or 6.
// RULE6 - Fetches only on word boundaries; program counter always even.
// RULE7 - Stack pointer stays even since stack traffic is whole words.
// RULE8 - Call and interrupt return addresses are saved on the stack.
// RULE9 - Push decrements before writing; pop increments after reading.
// RULE10 - Push of stack pointer stores it; pop into it reloads that value.
// RULE11 - Add overflow: same-sign operands giving opposite-sign result.
// RULE12 - Subtract overflow: pos minus neg gives neg, or neg minus pos gives pos.
// RULE13 - Two status bits pick one of four clock generator activity states.
// RULE14 - Oscillator disable stops all; external irq with enable, or NMI, wakes.
// RULE15 - Core halt stops execution; any enabled interrupt resumes.
// RULE16 - Global enable set lets maskable interrupts in; clear blocks them.
// RULE17 - Interrupt entry clears global enable; return restores saved status.
// RULE18 - Negative flag copies bit 15 for words, bit 7 for bytes.
// RULE19 - Zero flag set when result is zero, else cleared.
// RULE20 - Carry set on carry out; some operations load inverted zero.
// RULE21 - Constant registers give 4, 8 or 0, 1, 2, all-ones per mode bits.
// RULE22 - Arithmetic flags change only on operations that define them.
// RULE23 - Bit 0 of program counter and stack pointer forced low on write.
module crs_core_regs #(
  parameter int NREG = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic irq_pending,
  input wire logic ext_irq_pending,
  input wire logic nmi_pending,
  output logic core_running,
  output logic osc_running,
  output logic [1:0] clock_gen_sel
);
  logic [15:0] regs [0:NREG-1];
  logic [15:0] opnd;
  logic [15:0] result;
  crs_pkg::crs_op_t op;
  crs_pkg::crs_state_t state;
  logic [3:0] ra;

  // Word alignment of pointer registers on any write
  function automatic logic [15:0] crs_align(input logic [3:0] idx, input logic [15:0] v);
    crs_align = (idx == `CRS_R_PC || idx == `CRS_R_SP) ? {v[15:1], 1'b0} : v; // RULE23 RULE6 RULE7
  endfunction

  // Constant generator selected by register and mode bits
  function automatic logic [15:0] crs_const(input logic [3:0] r, input logic [1:0] as);
    logic [15:0] k;
    k = `CRS_K_0;
    if (r == `CRS_R_SR)
      k = (as == 2'h2) ? `CRS_K_4 : (as == 2'h3) ? `CRS_K_8 : `CRS_K_0; // RULE21
    else if (r == `CRS_R_CG)
      k = (as == 2'h1) ? `CRS_K_1 : (as == 2'h2) ? `CRS_K_2 : (as == 2'h3) ? `CRS_K_M1 : `CRS_K_0; // RULE21
    crs_const = k;
  endfunction

  // APB decode
  wire acc = psel & penable & ~pready;
  wire wr = acc & pwrite;
  wire in_gpr = paddr <= `CRS_OFF_GPR_LAST;
  wire [3:0] aidx = paddr[5:2];
  wire is_cmd = paddr == `CRS_OFF_CMD;
  wire is_opnd = paddr == `CRS_OFF_OPND;
  wire mapped = in_gpr | is_cmd | is_opnd | paddr == `CRS_OFF_RES | paddr == `CRS_OFF_STAT;
  wire idle = state == crs_pkg::S_IDLE;
  wire [15:0] sr = regs[`CRS_R_SR];
  wire [15:0] pc = regs[`CRS_R_PC];
  wire [15:0] sp = regs[`CRS_R_SP];
  wire irq_en = sr[`CRS_SR_IRQ_EN];
  wire halted = sr[`CRS_SR_HALT] | sr[`CRS_SR_OSC];

  // Command fields taken straight from the write data
  wire crs_pkg::crs_op_t c_op = crs_pkg::crs_op_t'(pwdata[`CRS_F_OP]);
  wire [3:0] c_ra = pwdata[`CRS_F_RA];
  wire [3:0] c_rb = pwdata[`CRS_F_RB];
  wire c_byte = pwdata[`CRS_F_BYTE];
  wire [1:0] c_as = pwdata[`CRS_F_AS];
  wire c_nmi = pwdata[`CRS_F_NMI];
  wire c_alu = c_op inside {crs_pkg::OP_ADD, crs_pkg::OP_ADDC, crs_pkg::OP_SUB,
                            crs_pkg::OP_SUBC, crs_pkg::OP_CMP, crs_pkg::OP_AND};
  wire c_dst_ok = c_rb != `CRS_R_SR && c_rb != `CRS_R_CG;
  wire c_irq_ok = c_nmi | irq_en; // RULE16
  wire c_len_ok = c_ra[1:0] != 2'h0;

  // Legality of a command; a halted core takes only interrupt entry
  wire cmd_ok = idle & (~halted | c_op == crs_pkg::OP_IRQ) &
                (c_op != crs_pkg::OP_STEP | c_len_ok) &
                (c_op != crs_pkg::OP_IRQ | c_irq_ok) &
                (~c_alu | c_dst_ok); // RULE15 RULE14
  wire go = wr & is_cmd & cmd_ok;
  wire gpr_wr = wr & in_gpr & idle;
  wire refuse = ~mapped | (wr & in_gpr & ~idle) | (wr & is_cmd & ~cmd_ok);

  // Arithmetic on the addressed operands
  wire [15:0] opa = regs[c_ra];
  wire [15:0] opb = regs[c_rb];
  wire sub = c_op inside {crs_pkg::OP_SUB, crs_pkg::OP_SUBC, crs_pkg::OP_CMP};
  wire is_and = c_op == crs_pkg::OP_AND;
  wire [15:0] a_in = sub ? ~opa : opa;
  wire cin = (c_op == crs_pkg::OP_ADDC || c_op == crs_pkg::OP_SUBC) ? sr[`CRS_SR_C] : sub;
  wire [16:0] sumw = {1'b0, opb} + {1'b0, a_in} + {16'h0000, cin};
  wire [8:0] sumb = {1'b0, opb[7:0]} + {1'b0, a_in[7:0]} + {8'h00, cin};
  wire [15:0] raw = is_and ? (opa & opb) : sumw[15:0];
  wire [15:0] resm = c_byte ? {8'h00, is_and ? raw[7:0] : sumb[7:0]} : raw;
  wire f_n = c_byte ? resm[7] : resm[15]; // RULE18
  wire f_z = resm == 16'h0000; // RULE19
  wire f_c = is_and ? ~f_z : (c_byte ? sumb[8] : sumw[16]); // RULE20
  wire vw = a_in[15] == opb[15] && resm[15] != opb[15];
  wire vb = a_in[7] == opb[7] && resm[7] != opb[7];
  wire f_v = ~is_and & (c_byte ? vb : vw); // RULE11 RULE12

  // Stack arithmetic; a push of the stack pointer stores the lowered value
  wire [15:0] sp_dec = sp - `CRS_WORD;
  wire [15:0] sp_inc = sp + `CRS_WORD;
  wire [15:0] push_val = (c_ra == `CRS_R_SP) ? sp_dec : opa; // RULE10
  wire [15:0] step = {13'h0, c_ra[1:0], 1'b0};

  // Wake conditions for the two low-power bits
  wire wake_halt = ((irq_pending | ext_irq_pending) & irq_en) | nmi_pending; // RULE15
  wire wake_osc = (ext_irq_pending & irq_en) | nmi_pending; // RULE14
  wire ack = ~idle & mem_ack;
  wire [15:0] rd_al = crs_align(ra, mem_rdata);
  wire [15:0] rd_pc = crs_align(`CRS_R_PC, mem_rdata);
  wire [15:0] stat = {11'h0, sr[`CRS_SR_CG_HI], sr[`CRS_SR_CG_LO], sr[`CRS_SR_OSC],
                      sr[`CRS_SR_HALT], ~idle};
  wire [15:0] rd_val = in_gpr ? (aidx == `CRS_R_CG ? `CRS_K_0 : regs[aidx]) :
                       is_opnd ? opnd : paddr == `CRS_OFF_RES ? result :
                       paddr == `CRS_OFF_STAT ? stat : 16'h0000;

  // APB answer one cycle after the access phase starts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= acc;
      pslverr <= acc & refuse;
      prdata <= (acc & ~pwrite) ? {16'h0000, rd_val} : 32'h00000000;
    end
  end

  // Operand register for call targets and vector addresses
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      opnd <= 16'h0000;
    else if (wr & is_opnd)
      opnd <= pwdata[15:0];
  end

  // Register file, flags and stack updates
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NREG; i++)
        regs[i] <= `CRS_REG_RST; // RULE1
      result <= 16'h0000;
    end
    else
    begin
      if (sr[`CRS_SR_HALT] & wake_halt)
        regs[`CRS_R_SR][`CRS_SR_HALT] <= 1'b0; // RULE15
      if (sr[`CRS_SR_OSC] & wake_osc)
        regs[`CRS_R_SR][`CRS_SR_OSC] <= 1'b0; // RULE14
      if (gpr_wr && aidx != `CRS_R_CG)
        regs[aidx] <= crs_align(aidx, pwdata[15:0]); // RULE2 RULE23
      if (go)
      begin
        case (c_op)
          crs_pkg::OP_STEP: regs[`CRS_R_PC] <= pc + step; // RULE5
          crs_pkg::OP_PUSH, crs_pkg::OP_CALL, crs_pkg::OP_IRQ:
            regs[`CRS_R_SP] <= sp_dec; // RULE9 RULE7
          crs_pkg::OP_CONST: result <= crs_const(c_ra, c_as); // RULE21
          crs_pkg::OP_NOP, crs_pkg::OP_FETCH, crs_pkg::OP_POP, crs_pkg::OP_RET,
          crs_pkg::OP_IRQ_RET: ;
          default:
          begin
            if (c_op != crs_pkg::OP_CMP)
              regs[c_rb] <= crs_align(c_rb, resm);
            result <= resm;
            regs[`CRS_R_SR][`CRS_SR_V] <= f_v; // RULE22
            regs[`CRS_R_SR][`CRS_SR_N] <= f_n;
            regs[`CRS_R_SR][`CRS_SR_Z] <= f_z;
            regs[`CRS_R_SR][`CRS_SR_C] <= f_c;
          end
        endcase
      end
      if (ack)
      begin
        case (state)
          crs_pkg::S_PUSH:
            if (op == crs_pkg::OP_CALL)
              regs[`CRS_R_PC] <= crs_align(`CRS_R_PC, opnd); // RULE8
            else if (op == crs_pkg::OP_IRQ)
              regs[`CRS_R_SP] <= sp_dec; // RULE8
          crs_pkg::S_PUSH2:
          begin
            regs[`CRS_R_SR][`CRS_SR_IRQ_EN] <= 1'b0; // RULE17
            regs[`CRS_R_SR][`CRS_SR_HALT] <= 1'b0;
            regs[`CRS_R_SR][`CRS_SR_OSC] <= 1'b0;
          end
          crs_pkg::S_READ:
            case (op)
              crs_pkg::OP_POP:
                if (ra == `CRS_R_SP)
                  regs[`CRS_R_SP] <= rd_al; // RULE10
                else
                begin
                  regs[`CRS_R_SP] <= sp_inc; // RULE9
                  if (ra != `CRS_R_CG)
                    regs[ra] <= rd_al;
                end
              crs_pkg::OP_RET:
              begin
                regs[`CRS_R_PC] <= rd_pc;
                regs[`CRS_R_SP] <= sp_inc;
              end
              crs_pkg::OP_FETCH:
              begin
                result <= mem_rdata;
                regs[`CRS_R_PC] <= pc + `CRS_WORD; // RULE5
              end
              crs_pkg::OP_IRQ: regs[`CRS_R_PC] <= rd_pc;
              crs_pkg::OP_IRQ_RET:
              begin
                regs[`CRS_R_SR] <= mem_rdata; // RULE17
                regs[`CRS_R_SP] <= sp_inc;
              end
              default: ;
            endcase
          crs_pkg::S_READ2:
          begin
            regs[`CRS_R_PC] <= rd_pc;
            regs[`CRS_R_SP] <= sp_inc;
          end
          default: ;
        endcase
      end
    end
  end

  // Bus sequencer: one request held until acknowledged
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= crs_pkg::S_IDLE;
      op <= crs_pkg::OP_NOP;
      ra <= 4'h0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
    end
    else if (go)
    begin
      op <= c_op;
      ra <= c_ra;
      case (c_op)
        crs_pkg::OP_PUSH, crs_pkg::OP_CALL, crs_pkg::OP_IRQ:
        begin
          state <= crs_pkg::S_PUSH;
          mem_req <= 1'b1;
          mem_we <= 1'b1;
          mem_addr <= sp_dec; // RULE9 RULE3
          mem_wdata <= (c_op == crs_pkg::OP_PUSH) ? push_val : pc; // RULE8
        end
        crs_pkg::OP_POP, crs_pkg::OP_RET, crs_pkg::OP_IRQ_RET, crs_pkg::OP_FETCH:
        begin
          state <= crs_pkg::S_READ;
          mem_req <= 1'b1;
          mem_we <= 1'b0;
          mem_addr <= (c_op == crs_pkg::OP_FETCH) ? pc : sp; // RULE4 RULE6
        end
        default: ;
      endcase
    end
    else if (ack)
    begin
      case (state)
        crs_pkg::S_PUSH:
          if (op == crs_pkg::OP_IRQ)
          begin
            state <= crs_pkg::S_PUSH2;
            mem_addr <= sp_dec;
            mem_wdata <= sr;
          end
          else
          begin
            state <= crs_pkg::S_IDLE;
            mem_req <= 1'b0;
          end
        crs_pkg::S_PUSH2:
        begin
          state <= crs_pkg::S_READ;
          mem_we <= 1'b0;
          mem_addr <= opnd;
        end
        crs_pkg::S_READ:
          if (op == crs_pkg::OP_IRQ_RET)
          begin
            state <= crs_pkg::S_READ2;
            mem_addr <= sp_inc;
          end
          else
          begin
            state <= crs_pkg::S_IDLE;
            mem_req <= 1'b0;
          end
        default:
        begin
          state <= crs_pkg::S_IDLE;
          mem_req <= 1'b0;
        end
      endcase
    end
  end

  // Low-power and clock generator status driven out of flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_running <= 1'b0;
      osc_running <= 1'b0;
      clock_gen_sel <= 2'h0;
    end
    else
    begin
      core_running <= ~sr[`CRS_SR_HALT] & ~sr[`CRS_SR_OSC];
      osc_running <= ~sr[`CRS_SR_OSC];
      clock_gen_sel <= {sr[`CRS_SR_CG_HI], sr[`CRS_SR_CG_LO]}; // RULE13
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence push_start_s;
    go && c_op == crs_pkg::OP_PUSH && c_ra != `CRS_R_SP;
  endsequence
  sequence push_issue_s;
    mem_req && mem_we && mem_addr == regs[`CRS_R_SP];
  endsequence

  pc_even_a: assert property (pc[0] == 1'b0) else $error("odd program counter"); // RULE6
  sp_even_a: assert property (sp[0] == 1'b0) else $error("odd stack pointer"); // RULE7
  push_predec_a: assert property (push_start_s |=> push_issue_s ##0 sp == $past(sp) - `CRS_WORD) // RULE9
    else $error("push did not predecrement");
  pop_postinc_a: assert property (ack && state == crs_pkg::S_READ && op == crs_pkg::OP_POP // RULE9
    && ra > `CRS_R_SP |=> sp == $past(mem_addr) + `CRS_WORD) else $error("pop did not postincrement");
  step_len_a: assert property (go && c_op == crs_pkg::OP_STEP && !(gpr_wr && aidx == `CRS_R_PC) // RULE5
    |=> pc == $past(pc) + {$past(c_ra[1:0]), 1'b0}) else $error("bad pc step");
  add_ovf_a: assert property (go && c_op == crs_pkg::OP_ADD && !c_byte // RULE11
    |=> sr[`CRS_SR_V] == ($past(opa[15]) == $past(opb[15]) && result[15] != $past(opb[15])))
    else $error("add overflow wrong");
  irq_mask_a: assert property (ack && state == crs_pkg::S_PUSH2 |=> !irq_en ##1 1'b1) // RULE17
    else $error("irq enable kept on interrupt");
  wake_halt_a: assert property (sr[`CRS_SR_HALT] && !sr[`CRS_SR_OSC] && wake_halt && !gpr_wr // RULE15
    |=> !sr[`CRS_SR_HALT] ##1 core_running) else $error("halt not woken");
  flags_hold_a: assert property (!go && !ack && !gpr_wr // RULE22
    |=> $stable({sr[`CRS_SR_V], sr[`CRS_SR_N], sr[`CRS_SR_Z], sr[`CRS_SR_C]})) else $error("flags moved");
  const_gen_a: assert property (go && c_op == crs_pkg::OP_CONST && c_ra == `CRS_R_CG && c_as == 2'h3 // RULE21
    |=> result == `CRS_K_M1) else $error("constant wrong");
endmodule // crs_core_regs

// >>> shared/crs_defines.svh
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH
// Register map, byte addresses on the APB side
`define CRS_OFF_GPR_LAST 8'h3c
`define CRS_OFF_CMD 8'h40
`define CRS_OFF_OPND 8'h44
`define CRS_OFF_RES 8'h48
`define CRS_OFF_STAT 8'h4c
// Status register bit positions
`define CRS_SR_C 0
`define CRS_SR_Z 1
`define CRS_SR_N 2
`define CRS_SR_IRQ_EN 3
`define CRS_SR_HALT 4
`define CRS_SR_OSC 5
`define CRS_SR_CG_LO 6
`define CRS_SR_CG_HI 7
`define CRS_SR_V 8
// Command word fields
`define CRS_F_OP 3:0
`define CRS_F_RA 7:4
`define CRS_F_RB 11:8
`define CRS_F_BYTE 12
`define CRS_F_AS 14:13
`define CRS_F_NMI 15
// Dedicated register numbers
`define CRS_R_PC 4'h0
`define CRS_R_SP 4'h1
`define CRS_R_SR 4'h2
`define CRS_R_CG 4'h3
// Reset value of every register
`define CRS_REG_RST 16'h0000
// Generated constants
`define CRS_K_0 16'h0000
`define CRS_K_1 16'h0001
`define CRS_K_2 16'h0002
`define CRS_K_4 16'h0004
`define CRS_K_8 16'h0008
`define CRS_K_M1 16'hffff
// One word in bytes
`define CRS_WORD 16'h0002
`endif

// >>> shared/crs_pkg.sv
package crs_pkg;
  typedef enum logic [3:0] {
    OP_NOP, OP_STEP, OP_FETCH, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_IRQ,
    OP_IRQ_RET, OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMP, OP_AND, OP_CONST
  } crs_op_t;
  typedef enum logic [2:0] {
    S_IDLE, S_PUSH, S_PUSH2, S_READ, S_READ2
  } crs_state_t;
endpackage

// >>> test/crs_mem_model.sv
`timescale 1ns/10ps
// Word memory on the shared code, data and peripheral bus
module crs_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [15:0] mem [0:32767];
  logic [1:0] cnt;
  // Ack after zero or three wait cycles; data lines toggle when not answering
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 16'h5a5a;
    end
    else if (mem_ack)
    begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && mem_we)
        mem[mem_addr[15:1]] <= mem_wdata;
    end
    else if (mem_req && cnt >= (slow ? 2'h3 : 2'h0))
    begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[15:1]];
    end
    else
    begin
      cnt <= mem_req ? cnt + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // crs_mem_model

// >>> test/cpu_core_register_set_tb_top.sv
`timescale 1ns/10ps
`include "crs_defines.svh"
module cpu_core_register_set_tb_top;
  typedef struct packed {
    crs_pkg::crs_op_t op;
    logic [3:0] ra;
    logic by;
    logic [1:0] as;
    logic [15:0] a, b, sr0, res;
    logic [3:0] fl, fm;
  } crs_row_t;
  // Operand a, operand b, status preset, result, flags {V,N,Z,C} and mask
  crs_row_t rows [14] = '{
    '{crs_pkg::OP_ADD, 4'h4, 1'b0, 2'h0, 16'h0001, 16'h7fff, 16'h0000, 16'h8000, 4'hc, 4'hf},
    '{crs_pkg::OP_ADD, 4'h4, 1'b0, 2'h0, 16'h0001, 16'hffff, 16'h0000, 16'h0000, 4'h3, 4'hf},
    '{crs_pkg::OP_ADD, 4'h4, 1'b1, 2'h0, 16'h0001, 16'h007f, 16'h0000, 16'h0080, 4'hc, 4'hf},
    '{crs_pkg::OP_ADDC, 4'h4, 1'b0, 2'h0, 16'h0001, 16'h0001, 16'h0001, 16'h0003, 4'h0, 4'hf},
    '{crs_pkg::OP_SUB, 4'h4, 1'b0, 2'h0, 16'h0001, 16'h8000, 16'h0000, 16'h7fff, 4'h9, 4'hf},
    '{crs_pkg::OP_SUB, 4'h4, 1'b0, 2'h0, 16'hffff, 16'h7fff, 16'h0000, 16'h8000, 4'hc, 4'hf},
    '{crs_pkg::OP_SUB, 4'h4, 1'b1, 2'h0, 16'h0001, 16'h0080, 16'h0000, 16'h007f, 4'h9, 4'hf},
    '{crs_pkg::OP_SUBC, 4'h4, 1'b0, 2'h0, 16'h0003, 16'h0005, 16'h0000, 16'h0001, 4'h1, 4'hf},
    '{crs_pkg::OP_CMP, 4'h4, 1'b0, 2'h0, 16'h0005, 16'h0005, 16'h0000, 16'h0000, 4'h3, 4'hf},
    '{crs_pkg::OP_AND, 4'h4, 1'b0, 2'h0, 16'h000f, 16'h00f0, 16'h0000, 16'h0000, 4'h2, 4'h7},
    '{crs_pkg::OP_CONST, 4'h2, 1'b0, 2'h2, 16'h0000, 16'h0000, 16'h0107, 16'h0004, 4'hf, 4'hf},
    '{crs_pkg::OP_CONST, 4'h3, 1'b0, 2'h0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h0, 4'hf},
    '{crs_pkg::OP_CONST, 4'h3, 1'b0, 2'h2, 16'h0000, 16'h0000, 16'h0107, 16'h0002, 4'hf, 4'hf},
    '{crs_pkg::OP_CONST, 4'h3, 1'b0, 2'h3, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 4'h0, 4'hf}
  };
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic irq_pending = 1'b0, ext_irq_pending = 1'b0, nmi_pending = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, mem_req, mem_we, mem_ack, core_running, osc_running, er;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [1:0] clock_gen_sel;
  int mismatches = 0, n_checks = 0;

  always #10 clk = ~clk;

  crs_core_regs dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq_pending(irq_pending),
    .ext_irq_pending(ext_irq_pending), .nmi_pending(nmi_pending), .core_running(core_running),
    .osc_running(osc_running), .clock_gen_sel(clock_gen_sel));
  crs_mem_model mem_m (.clk(clk), .rst_n(rst_n), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  // Comparison, bus cycles and command words
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      chk("pready", 32'h0, 32'h1);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk($sformatf("read %h", a), rd, e);
  endtask
  task stw(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      apb(`CRS_OFF_STAT, 1'b0, 32'h0);
      n++;
    end
    while ((rd & m) !== v && n < 30);
    chk("status wait", rd & m, v);
  endtask
  function automatic logic [31:0] cm(input crs_pkg::crs_op_t op, input logic [3:0] a, input logic nmi);
    return {16'h0000, nmi, 3'h0, 4'h5, a, op};
  endfunction
  function automatic logic [7:0] rg(input int r);
    return 8'(r * 4);
  endfunction
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test;
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    chk("run in reset", 32'(core_running), 32'h0);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int r = 0; r < 3; r++) rdc(rg(r), 32'(`CRS_REG_RST));
    chk("osc", 32'(osc_running), 32'h1);
    wr(rg(4), 32'h0000a5a5);
    chk("legal write", 32'(er), 32'h0);
    rdc(rg(4), 32'h0000a5a5);
    wr(rg(15), 32'hffff1234);
    rdc(rg(15), 32'h00001234);
    wr(rg(0), 32'h00001235);
    rdc(rg(0), 32'h00001234);
    wr(rg(1), 32'h0000ffff);
    rdc(rg(1), 32'h0000fffe);
    wr(rg(3), 32'h00007777);
    rdc(rg(3), 32'h0);
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_ADD, 4'h4, 1'b0) ^ 32'h00000700);
    chk("alu to status", 32'(er), 32'h1);
    apb(8'h80, 1'b0, 32'h0);
    chk("unmapped", 32'(er), 32'h1);
    foreach (rows[i])
    begin
      wr(rg(4), 32'(rows[i].a));
      wr(rg(5), 32'(rows[i].b));
      wr(rg(2), 32'(rows[i].sr0));
      wr(`CRS_OFF_CMD, cm(rows[i].op, rows[i].ra, 1'b0) | {17'h0, rows[i].as, rows[i].by, 12'h0});
      rdc(`CRS_OFF_RES, 32'(rows[i].res));
      apb(rg(2), 1'b0, 32'h0);
      chk("flags", 32'({rd[8], rd[2:0]} & rows[i].fm), 32'(rows[i].fl & rows[i].fm));
    end
    wr(rg(2), 32'h0);
    wr(rg(0), 32'h0100);
    for (int k = 1; k < 4; k++)
    begin
      wr(`CRS_OFF_CMD, cm(crs_pkg::OP_STEP, 4'(k), 1'b0));
      rdc(rg(0), 32'(32'h100 + k * (k + 1)));
    end
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_STEP, 4'h0, 1'b0));
    chk("step zero", 32'(er), 32'h1);
    slow <= 1'b1;
    wr(rg(1), 32'h0400);
    wr(rg(6), 32'hbeef);
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_PUSH, 4'h6, 1'b0));
    wr(rg(6), 32'h1111);
    chk("busy write", 32'(er), 32'h1);
    stw(32'h1, 32'h0);
    rdc(rg(1), 32'h03fe);
    chk("push", 32'(mem_m.mem[16'h01ff]), 32'hbeef);
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_POP, 4'h7, 1'b0));
    stw(32'h1, 32'h0);
    rdc(rg(7), 32'hbeef);
    rdc(rg(1), 32'h0400);
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_PUSH, 4'h1, 1'b0));
    stw(32'h1, 32'h0);
    chk("push sp", 32'(mem_m.mem[16'h01ff]), 32'h03fe);
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_POP, 4'h1, 1'b0));
    stw(32'h1, 32'h0);
    rdc(rg(1), 32'h03fe);
    slow <= 1'b0;
    wr(rg(1), 32'h0400);
    wr(rg(0), 32'h0100);
    wr(`CRS_OFF_OPND, 32'h2000);
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_CALL, 4'h0, 1'b0));
    stw(32'h1, 32'h0);
    rdc(rg(0), 32'h2000);
    chk("call", 32'(mem_m.mem[16'h01ff]), 32'h0100);
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_RET, 4'h0, 1'b0));
    stw(32'h1, 32'h0);
    rdc(rg(0), 32'h0100);
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_IRQ, 4'h0, 1'b0));
    chk("irq masked", 32'(er), 32'h1);
    wr(rg(2), 32'h0009);
    wr(`CRS_OFF_OPND, 32'h3000);
    rdc(`CRS_OFF_OPND, 32'h3000);
    mem_m.mem[16'h1800] = 16'h4000;
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_IRQ, 4'h0, 1'b0));
    stw(32'h1, 32'h0);
    rdc(rg(0), 32'h4000);
    rdc(rg(2), 32'h0001);
    chk("irq sr", 32'(mem_m.mem[16'h01fe]), 32'h0009);
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_IRQ_RET, 4'h0, 1'b0));
    stw(32'h1, 32'h0);
    rdc(rg(2), 32'h0009);
    rdc(rg(1), 32'h0400);
    mem_m.mem[16'h0080] = 16'h3c3c;
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_FETCH, 4'h0, 1'b0));
    stw(32'h1, 32'h0);
    rdc(`CRS_OFF_RES, 32'h3c3c);
    rdc(rg(0), 32'h0102);
    wr(rg(2), 32'h0);
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_IRQ, 4'h0, 1'b1));
    chk("nmi taken", 32'(er), 32'h0);
    stw(32'h1, 32'h0);
    rdc(rg(0), 32'h4000);
    chk("nmi push", 32'(mem_m.mem[16'h01ff]), 32'h0102);
    for (int k = 0; k < 4; k++)
    begin
      wr(rg(2), 32'(k) << 6);
      repeat (2) @(posedge clk);
      chk("clock select", 32'(clock_gen_sel), 32'(k));
    end
    wr(rg(2), 32'h0018);
    repeat (2) @(posedge clk);
    chk("halted", 32'({core_running, osc_running}), 32'h1);
    wr(`CRS_OFF_CMD, cm(crs_pkg::OP_STEP, 4'h1, 1'b0));
    chk("step halted", 32'(er), 32'h1);
    irq_pending <= 1'b1;
    stw(32'h2, 32'h0);
    irq_pending <= 1'b0;
    wr(rg(2), 32'h0028);
    irq_pending <= 1'b1;
    repeat (10) @(posedge clk);
    chk("osc off", 32'({core_running, osc_running}), 32'h0);
    irq_pending <= 1'b0;
    ext_irq_pending <= 1'b1;
    stw(32'h4, 32'h0);
    ext_irq_pending <= 1'b0;
    repeat (2) @(posedge clk);
    chk("woken", 32'({core_running, osc_running}), 32'h3);
    wr(rg(2), 32'h0020);
    ext_irq_pending <= 1'b1;
    repeat (10) @(posedge clk);
    chk("no irq enable", 32'(osc_running), 32'h0);
    ext_irq_pending <= 1'b0;
    nmi_pending <= 1'b1;
    stw(32'h4, 32'h0);
    nmi_pending <= 1'b0;
    finish_test;
  end
endmodule // cpu_core_register_set_tb_top
